//--- inc/qd_pkg.sv
// Constants and types of the quadrature decoder
// Operation
// - Decode two phases into direction and position
// - Count up forward, down reverse
// - Control bit selects 2x or 4x counting
// - Index pulse clears position when enabled
// - Capture pulse count each velocity timer period
// - Interrupt when captured velocity below threshold
// - Position and velocity held in 32 bits
// - Three position compares, each own interrupt
// - Index counter counts whole revolutions
// - Index counter compare raises interrupt
// - Optional combined index and position interrupt
// - Inputs filtered by programmable stable count
// - Alternative clock and direction input mode
package qd_pkg;
   localparam logic [7:0]  OFS_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_FILT  = 8'h04;
   localparam logic [7:0]  OFS_POS   = 8'h08;
   localparam logic [7:0]  OFS_VRLD  = 8'h0C;
   localparam logic [7:0]  OFS_VCAP  = 8'h10;
   localparam logic [7:0]  OFS_VCMP  = 8'h14;
   localparam logic [7:0]  OFS_CMP0  = 8'h18;
   localparam logic [7:0]  OFS_CMP1  = 8'h1C;
   localparam logic [7:0]  OFS_CMP2  = 8'h20;
   localparam logic [7:0]  OFS_ICNT  = 8'h24;
   localparam logic [7:0]  OFS_ICMP  = 8'h28;
   localparam logic [7:0]  OFS_STAT  = 8'h2C;
   localparam logic [7:0]  OFS_MASK  = 8'h30;
   localparam logic [7:0]  OFS_DIR   = 8'h34;
   localparam int          NEV       = 7;
   localparam int          EV_CMP0   = 0;
   localparam int          EV_IDX    = 3;
   localparam int          EV_ICMP   = 4;
   localparam int          EV_VLESS  = 5;
   localparam int          EV_COMB   = 6;
   localparam logic [15:0] FILT_RST  = 16'h0003;
   localparam logic [31:0] VRLD_RST  = 32'h000F423F;
   typedef struct packed {
      logic combine;
      logic idx_clr;
      logic dirclk;
      logic mode4x;
      logic enable;
   } qd_ctrl_s;
   localparam qd_ctrl_s    CTRL_RST  = '{default: 1'b0};
   typedef struct packed {
      logic idx;
      logic b;
      logic a;
   } qd_enc_s;
endpackage

//--- test/qd_enc_model.sv
// Behavioural rotary encoder with index and raw clock/direction drive
`timescale 1ns/1ps
`default_nettype none
module qd_enc_model (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       step,
   input  wire logic       fwd,
   input  wire logic       idx,
   input  wire logic       raw,
   input  wire logic [1:0] raw_ab,
   output var qd_pkg::qd_enc_s enc
);
   logic [1:0] ph_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ph_r <= 2'h0;
      end else if (step) begin
         ph_r <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
      end
   end
   // Gray order 00,10,11,01 (a,b): A leads B when moving forward
   assign enc = raw ? {idx, raw_ab[1], raw_ab[0]} : {idx, ph_r[1], ph_r[1] ^ ph_r[0]};
endmodule // qd_enc_model
`default_nettype wire

//--- test/qd_quadrature_decoder_tb_top.sv
// Self-checking bench of the quadrature decoder
`timescale 1ns/1ps
`default_nettype none
module qd_quadrature_decoder_tb_top;
   logic            clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, serr;
   logic            step, fwd, idx, raw;
   logic [1:0]      raw_ab;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rdat;
   qd_pkg::qd_enc_s enc;
   int              miscompares, checked;

   qd_quadrature_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .enc(enc), .irq(irq));
   qd_enc_model enc_u (.clk_sys(clk_sys), .rst(rst), .step(step), .fwd(fwd), .idx(idx),
      .raw(raw), .raw_ab(raw_ab), .enc(enc));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic mv(input logic f, input int n);
      repeat (n) begin
         step <= 1'b1; fwd <= f;
         @(posedge clk_sys);
         step <= 1'b0;
         repeat (11) @(posedge clk_sys);
      end
   endtask
   task automatic hold(input logic i, input logic [1:0] ab, input int n);
      idx <= i; raw_ab <= ab;
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic t_reset;
      rd(qd_pkg::OFS_CTRL, 32'h0);
      rd(qd_pkg::OFS_FILT, 32'h3);
      rd(qd_pkg::OFS_VRLD, 32'h000F423F);
      rd(8'h3C, 32'h0);
      chk({31'h0, serr}, 32'h1);
   endtask
   task automatic t_count;
      wr(qd_pkg::OFS_CTRL, 32'h3);
      mv(1'b1, 8);
      rd(qd_pkg::OFS_POS, 32'h8);
      rd(qd_pkg::OFS_DIR, 32'h1);
      mv(1'b0, 11);
      rd(qd_pkg::OFS_POS, 32'hFFFFFFFD);
      rd(qd_pkg::OFS_DIR, 32'h0);
      wr(qd_pkg::OFS_CTRL, 32'h1);
      mv(1'b1, 8);
      rd(qd_pkg::OFS_POS, 32'h1);
   endtask
   task automatic t_cmp;
      wr(qd_pkg::OFS_CTRL, 32'h3);
      wr(qd_pkg::OFS_MASK, 32'h3);
      wr(qd_pkg::OFS_STAT, 32'h7F);
      for (int i = 0; i < 3; i++) wr(8'(qd_pkg::OFS_CMP0 + 4 * i), 32'(2 + i));
      for (int i = 0; i < 3; i++) begin
         mv(1'b1, 1);
         rd(qd_pkg::OFS_STAT, 32'h1 << i);
         chk({31'h0, irq}, 32'(i < 2));
         wr(qd_pkg::OFS_STAT, 32'h1 << i);
         chk({31'h0, irq}, 32'h0);
      end
   endtask
   task automatic t_index;
      wr(qd_pkg::OFS_CTRL, 32'h1B);
      wr(qd_pkg::OFS_ICMP, 32'h1);
      wr(qd_pkg::OFS_CMP0, 32'h1);
      wr(qd_pkg::OFS_MASK, 32'h7F);
      hold(1'b1, 2'h0, 6);
      hold(1'b0, 2'h0, 12);
      rd(qd_pkg::OFS_POS, 32'h0);
      rd(qd_pkg::OFS_ICNT, 32'h1);
      rd(qd_pkg::OFS_STAT, 32'h18);
      wr(qd_pkg::OFS_STAT, 32'h7F);
      mv(1'b1, 1);
      rd(qd_pkg::OFS_STAT, 32'h41);
      wr(qd_pkg::OFS_STAT, 32'h7F);
      mv(1'b0, 1);
      hold(1'b1, 2'h0, 6);
      hold(1'b0, 2'h0, 12);
      rd(qd_pkg::OFS_ICNT, 32'h0);
      wr(qd_pkg::OFS_STAT, 32'h7F);
   endtask
   task automatic t_vel;
      wr(qd_pkg::OFS_VCMP, 32'h5);
      wr(qd_pkg::OFS_VRLD, 32'h3E7);
      wr(qd_pkg::OFS_STAT, 32'h7F);
      // Restart the timer so its window opens just before the steps
      wr(qd_pkg::OFS_CTRL, 32'h0);
      wr(qd_pkg::OFS_CTRL, 32'h3);
      mv(1'b0, 10);
      repeat (900) @(posedge clk_sys);
      rd(qd_pkg::OFS_VCAP, 32'hA);
      rd(qd_pkg::OFS_STAT, 32'h0);
      repeat (1000) @(posedge clk_sys);
      rd(qd_pkg::OFS_VCAP, 32'h0);
      rd(qd_pkg::OFS_STAT, 32'h20);
   endtask
   task automatic t_raw;
      // Disabled while switching source, so the swap itself cannot count
      wr(qd_pkg::OFS_CTRL, 32'h0);
      raw <= 1'b1;
      hold(1'b0, 2'h2, 12);
      wr(qd_pkg::OFS_CTRL, 32'h5);
      repeat (2) begin
         hold(1'b0, 2'h3, 12);
         hold(1'b0, 2'h2, 12);
      end
      hold(1'b0, 2'h3, 2);
      hold(1'b0, 2'h2, 12);
      rd(qd_pkg::OFS_POS, 32'hFFFFFFF8);
      hold(1'b0, 2'h1, 12);
      hold(1'b0, 2'h0, 12);
      rd(qd_pkg::OFS_POS, 32'hFFFFFFF7);
      // Zero filter time: the same short pulse now counts
      wr(qd_pkg::OFS_FILT, 32'h0);
      hold(1'b0, 2'h3, 2);
      hold(1'b0, 2'h2, 12);
      rd(qd_pkg::OFS_POS, 32'hFFFFFFF8);
   endtask

   task automatic give_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end

   initial begin
      miscompares = 0; checked = 0; rst = 1'b1;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      step = 1'b0; fwd = 1'b0; idx = 1'b0; raw = 1'b0; raw_ab = 2'h0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_count();
      t_cmp();
      t_index();
      t_vel();
      t_raw();
      give_verdict();
   end
endmodule // qd_quadrature_decoder_tb_top
`default_nettype wire

//--- verilog/qd_quadrature_decoder.sv
// Quadrature decoder with velocity timer, compares and APB registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module qd_quadrature_decoder #(
   parameter int FILT_W = 16
) (
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic               pslverr,
   output logic [31:0]        prdata,
   input  wire qd_pkg::qd_enc_s enc,
   output logic               irq
);
   // Filter counter and its register are at most 16 bits wide
   if (FILT_W < 1 || FILT_W > 16) begin : g_chk
      $error("FILT_W must be 1 to 16");
   end

   qd_pkg::qd_ctrl_s ctrl_r;
   logic [FILT_W-1:0] filt_r;
   logic [31:0]       pos_r, vrld_r, vcap_r, vcmp_r, icnt_r, icmp_r;
   logic [31:0]       vtmr_r, vacc_r, prdata_r;
   logic [31:0]       cmp_r [3];
   localparam int     NEVW = qd_pkg::NEV;
   logic [NEVW-1:0]   stat_r, mask_r, ev;
   logic [2:0]        flt_r, fltp_r;
   logic [FILT_W-1:0] fcnt_r [3];
   logic              dir_r, pos_upd_r, icnt_upd_r, vcap_upd_r;
   logic              step, up, idx_rise, clr_pos, wr, acc;
   logic [31:0]       rdata;

   // Word aligned and inside the map; anything else is refused
   function automatic logic hit(input logic [7:0] a);
      hit = (a[1:0] == 2'h0) && (a <= qd_pkg::OFS_DIR);
   endfunction

   assign acc     = psel & penable;
   assign wr      = acc & pwrite & hit(paddr);
   // No wait states: every register answers in the access phase
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit(paddr);
   assign prdata  = prdata_r;

   // Input filter: a level is taken once stable for filt_r + 1 cycles
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flt_r  <= 3'h0;
         fltp_r <= 3'h0;
         for (int i = 0; i < 3; i++) fcnt_r[i] <= '0;
      end else begin
         fltp_r <= flt_r;
         for (int i = 0; i < 3; i++) begin
            if (enc[i] == flt_r[i]) begin
               fcnt_r[i] <= '0;
            end else if (fcnt_r[i] >= filt_r) begin
               flt_r[i]  <= enc[i];
               fcnt_r[i] <= '0;
            end else begin
               fcnt_r[i] <= fcnt_r[i] + 1'b1;
            end
         end
      end
   end

   // Decode; up = ~(a_prev ^ b) holds for both A and B edges
   always_comb begin
      step = 1'b0;
      up   = ~(fltp_r[0] ^ flt_r[1]);
      if (ctrl_r.dirclk) begin
         step = flt_r[0] & ~fltp_r[0];
         up   = flt_r[1];
      end else if (ctrl_r.mode4x) begin
         step = (flt_r[0] ^ fltp_r[0]) ^ (flt_r[1] ^ fltp_r[1]);
      end else begin
         step = flt_r[0] ^ fltp_r[0];
      end
      step = step & ctrl_r.enable;
   end

   assign idx_rise = ctrl_r.enable & flt_r[2] & ~fltp_r[2];
   assign clr_pos  = idx_rise & ctrl_r.idx_clr;

   // Position; index clear wins over a same-cycle step
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pos_r     <= 32'h0;
         dir_r     <= 1'b0;
         pos_upd_r <= 1'b0;
      end else begin
         pos_upd_r <= step | clr_pos;
         if (step) dir_r <= up;
         if (clr_pos) pos_r <= 32'h0;
         else if (step) pos_r <= up ? pos_r + 32'h1 : pos_r - 32'h1;
      end
   end

   // Revolution counter follows last seen direction
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         icnt_r     <= 32'h0;
         icnt_upd_r <= 1'b0;
      end else begin
         icnt_upd_r <= idx_rise;
         if (idx_rise) icnt_r <= dir_r ? icnt_r + 32'h1 : icnt_r - 32'h1;
      end
   end

   // Velocity: pulses per timer period, direction ignored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vtmr_r     <= qd_pkg::VRLD_RST;
         vacc_r     <= 32'h0;
         vcap_r     <= 32'h0;
         vcap_upd_r <= 1'b0;
      end else begin
         vcap_upd_r <= 1'b0;
         if (!ctrl_r.enable) begin
            vtmr_r <= vrld_r;
            vacc_r <= 32'h0;
         end else if (vtmr_r == 32'h0) begin
            vtmr_r     <= vrld_r;
            vcap_r     <= vacc_r + {31'h0, step};
            vacc_r     <= 32'h0;
            vcap_upd_r <= 1'b1;
         end else begin
            vtmr_r <= vtmr_r - 32'h1;
            vacc_r <= vacc_r + {31'h0, step};
         end
      end
   end

   // Events fire only when the compared value was just updated; the combined event needs only the position update
   always_comb begin
      ev = '0;
      for (int i = 0; i < 3; i++)
         ev[qd_pkg::EV_CMP0+i] = pos_upd_r & (pos_r == cmp_r[i]);
      ev[qd_pkg::EV_IDX]   = idx_rise;
      ev[qd_pkg::EV_ICMP]  = icnt_upd_r & (icnt_r == icmp_r);
      ev[qd_pkg::EV_VLESS] = vcap_upd_r & (vcap_r < vcmp_r);
      ev[qd_pkg::EV_COMB]  = ctrl_r.combine & ev[qd_pkg::EV_CMP0]
                             & (icnt_r == icmp_r);
   end

   // Sticky status, write one to clear; a new event wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_r <= '0;
      end else begin
         if (wr && paddr == qd_pkg::OFS_STAT)
            stat_r <= (stat_r & ~pwdata[NEVW-1:0]) | ev;
         else
            stat_r <= stat_r | ev;
      end
   end

   assign irq = |(stat_r & mask_r);

   // Software-written configuration
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_r <= qd_pkg::CTRL_RST;
         filt_r <= qd_pkg::FILT_RST[FILT_W-1:0];
         vrld_r <= qd_pkg::VRLD_RST;
         vcmp_r <= 32'h0;
         icmp_r <= 32'h0;
         mask_r <= '0;
         for (int i = 0; i < 3; i++) cmp_r[i] <= 32'h0;
      end else if (wr) begin
         case (paddr)
            qd_pkg::OFS_CTRL: ctrl_r <= qd_pkg::qd_ctrl_s'(pwdata[4:0]);
            qd_pkg::OFS_FILT: filt_r <= pwdata[FILT_W-1:0];
            qd_pkg::OFS_VRLD: vrld_r <= pwdata;
            qd_pkg::OFS_VCMP: vcmp_r <= pwdata;
            qd_pkg::OFS_CMP0: cmp_r[0] <= pwdata;
            qd_pkg::OFS_CMP1: cmp_r[1] <= pwdata;
            qd_pkg::OFS_CMP2: cmp_r[2] <= pwdata;
            qd_pkg::OFS_ICMP: icmp_r <= pwdata;
            qd_pkg::OFS_MASK: mask_r <= pwdata[NEVW-1:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rdata = 32'h0;
      case (paddr)
         qd_pkg::OFS_CTRL: rdata = {27'h0, ctrl_r};
         qd_pkg::OFS_FILT: rdata = 32'(filt_r);
         qd_pkg::OFS_POS:  rdata = pos_r;
         qd_pkg::OFS_VRLD: rdata = vrld_r;
         qd_pkg::OFS_VCAP: rdata = vcap_r;
         qd_pkg::OFS_VCMP: rdata = vcmp_r;
         qd_pkg::OFS_CMP0: rdata = cmp_r[0];
         qd_pkg::OFS_CMP1: rdata = cmp_r[1];
         qd_pkg::OFS_CMP2: rdata = cmp_r[2];
         qd_pkg::OFS_ICNT: rdata = icnt_r;
         qd_pkg::OFS_ICMP: rdata = icmp_r;
         qd_pkg::OFS_STAT: rdata = 32'(stat_r);
         qd_pkg::OFS_MASK: rdata = 32'(mask_r);
         qd_pkg::OFS_DIR:  rdata = {31'h0, dir_r};
         default:          rdata = 32'h0;
      endcase
   end

   // Read data captured in setup so it comes from a flip-flop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) prdata_r <= 32'h0;
      else if (psel && !penable) prdata_r <= rdata;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_POS_UP: assert property (step && up && !clr_pos |=> pos_r == $past(pos_r) + 32'h1)
      else $error("position did not count up");
   AST_POS_DN: assert property (step && !up && !clr_pos |=> pos_r == $past(pos_r) - 32'h1)
      else $error("position did not count down");
   AST_IDX_CLR: assert property (clr_pos |=> pos_r == 32'h0 && pos_upd_r)
      else $error("index did not clear position");
   AST_X2_B: assert property (!ctrl_r.mode4x && !ctrl_r.dirclk && $stable(flt_r[0])
                             && !clr_pos |=> $stable(pos_r))
      else $error("2x mode counted a B edge");
   AST_ICNT: assert property (idx_rise && dir_r |=> icnt_r == $past(icnt_r) + 32'h1)
      else $error("index counter did not increment");
   AST_VCAP: assert property (ctrl_r.enable && vtmr_r == 32'h0
                             |=> vcap_r == $past(vacc_r) + {31'h0, $past(step)})
      else $error("velocity capture wrong");
   AST_VLESS: assert property (vcap_upd_r && vcap_r < vcmp_r |=> stat_r[qd_pkg::EV_VLESS])
      else $error("velocity less-than flag missing");
   AST_CMP0: assert property (pos_upd_r && pos_r == cmp_r[0] |=> stat_r[qd_pkg::EV_CMP0])
      else $error("position compare flag missing");
   AST_FILT: assert property ($changed(flt_r[0]) |-> $past(fcnt_r[0]) >= $past(filt_r))
      else $error("filter passed an unstable level");
   AST_DIRCLK: assert property (ctrl_r.enable && ctrl_r.dirclk && flt_r[0] && !fltp_r[0]
                               |-> step && up == flt_r[1])
      else $error("clock and direction mode miscounted");
   AST_COMB: assert property (ev[qd_pkg::EV_COMB] |=> stat_r[qd_pkg::EV_COMB]
                             && stat_r[qd_pkg::EV_CMP0])
      else $error("combined flag missing");

   // Direction and enable gating
   AST_DIR: assert property (step |=> dir_r == $past(up))
      else $error("direction not taken from last step");
   AST_DISABLED: assert property (!ctrl_r.enable |=> $stable(pos_r)
                                 && $stable(icnt_r))
      else $error("counted while disabled");
   AST_POS_HOLD: assert property (!step && !clr_pos |=> $stable(pos_r))
      else $error("position moved without a step");

   // Resolution: which filtered edges make a step
   AST_X2_A: assert property (ctrl_r.enable && !ctrl_r.mode4x && !ctrl_r.dirclk
                             && $changed(flt_r[0]) |-> step)
      else $error("2x mode missed an A edge");
   AST_X4_A: assert property (ctrl_r.enable && ctrl_r.mode4x && !ctrl_r.dirclk
                             && $changed(flt_r[0]) && $stable(flt_r[1]) |-> step)
      else $error("4x mode missed an A edge");
   AST_X4_B: assert property (ctrl_r.enable && ctrl_r.mode4x && !ctrl_r.dirclk
                             && $changed(flt_r[1]) && $stable(flt_r[0]) |-> step)
      else $error("4x mode missed a B edge");

   // Revolution counter and its events
   AST_ICNT_DN: assert property (idx_rise && !dir_r |=> icnt_r == $past(icnt_r) - 32'h1)
      else $error("index counter did not decrement");
   AST_ICNT_HOLD: assert property (!idx_rise |=> $stable(icnt_r))
      else $error("index counter moved without an index pulse");
   AST_IDX_EV: assert property (idx_rise |=> stat_r[qd_pkg::EV_IDX])
      else $error("index flag missing");
   AST_ICMP: assert property (icnt_upd_r && icnt_r == icmp_r
                             |=> stat_r[qd_pkg::EV_ICMP])
      else $error("index compare flag missing");

   // Velocity timer
   AST_VCNT: assert property (ctrl_r.enable && vtmr_r != 32'h0
                             |=> vacc_r == $past(vacc_r) + {31'h0, $past(step)})
      else $error("velocity accumulator wrong");
   AST_VRELOAD: assert property (ctrl_r.enable && vtmr_r == 32'h0
                                |=> vtmr_r == $past(vrld_r) && vcap_upd_r)
      else $error("velocity timer did not reload");
   AST_VCAP_DIS: assert property (!ctrl_r.enable
                                 |=> vacc_r == 32'h0 && vtmr_r == $past(vrld_r))
      else $error("velocity timer not held while disabled");

   // Position compares, sticky status and interrupt
   AST_CMP1: assert property (pos_upd_r && pos_r == cmp_r[1]
                             |=> stat_r[qd_pkg::EV_CMP0+1])
      else $error("second position compare flag missing");
   AST_CMP2: assert property (pos_upd_r && pos_r == cmp_r[2]
                             |=> stat_r[qd_pkg::EV_CMP0+2])
      else $error("third position compare flag missing");
   AST_STICKY: assert property (stat_r[qd_pkg::EV_CMP0]
                               && !(wr && paddr == qd_pkg::OFS_STAT && pwdata[qd_pkg::EV_CMP0])
                               |=> stat_r[qd_pkg::EV_CMP0])
      else $error("compare flag lost without a clear");
   AST_W1C: assert property (wr && paddr == qd_pkg::OFS_STAT && pwdata[qd_pkg::EV_CMP0]
                            && !ev[qd_pkg::EV_CMP0] |=> !stat_r[qd_pkg::EV_CMP0])
      else $error("compare flag not cleared by a written one");
   AST_IRQ: assert property (stat_r[qd_pkg::EV_CMP0] && mask_r[qd_pkg::EV_CMP0] |-> irq)
      else $error("unmasked flag did not raise the interrupt");
endmodule // qd_quadrature_decoder
`default_nettype wire
